// ==== rtl/interp_stage.sv ====
/*
  One 2x interpolation stage: zero-stuffing symmetric FIR with
  pre-added mirrored taps, rounding and saturation.
  Assumes in_en_in only ever rises together with out_en_in.
*/
module interp_stage #(
  parameter int DATA_W = tx_interp_pkg::SAMPLE_W,
  parameter int NTAPS = tx_interp_pkg::HB1_TAPS,
  parameter int HALF = NTAPS / 2 + 1,
  parameter int SHIFT = tx_interp_pkg::HB1_SHIFT,
  parameter logic signed [tx_interp_pkg::COEF_W-1:0] COEF [HALF] =
    tx_interp_pkg::HB1_COEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic in_en_in,
  input wire logic out_en_in,
  input wire logic signed [DATA_W-1:0] sample_in,
  output logic signed [DATA_W-1:0] sample_out
);
  import tx_interp_pkg::*;
  localparam logic signed [ACC_W-1:0] MAX_S =
    ACC_W'((1 << (DATA_W - 1)) - 1);
  localparam logic signed [ACC_W-1:0] MIN_S = -MAX_S - ACC_W'(1);
  localparam logic signed [ACC_W-1:0] HALF_LSB = ACC_W'(1) <<< (SHIFT - 1);

  logic signed [DATA_W-1:0] line_reg [NTAPS];
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] rounded;
  logic signed [ACC_W-1:0] scaled;
  logic signed [DATA_W-1:0] sat;

  always_comb begin
    acc = '0;
    for (int k = 0; k < HALF - 1; k++) begin
      if (COEF[k] != '0) begin
        acc = acc + ACC_W'(COEF[k]) *
          (ACC_W'(line_reg[k]) + ACC_W'(line_reg[NTAPS-1-k]));
      end
    end
    acc = acc + ACC_W'(COEF[HALF-1]) * ACC_W'(line_reg[HALF-1]);
  end

  assign rounded = acc + HALF_LSB;
  assign scaled = rounded >>> SHIFT;
  assign sat = (scaled > MAX_S) ? MAX_S[DATA_W-1:0] :
               (scaled < MIN_S) ? MIN_S[DATA_W-1:0] : scaled[DATA_W-1:0];

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || flush_in) begin
      for (int k = 0; k < NTAPS; k++) begin
        line_reg[k] <= '0;
      end
      sample_out <= '0;
    end else if (out_en_in) begin
      line_reg[0] <= in_en_in ? sample_in : '0;
      for (int k = 1; k < NTAPS; k++) begin
        line_reg[k] <= line_reg[k-1];
      end
      sample_out <= sat;
    end
  end

  a_zero_stuff: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    out_en_in && !in_en_in && !flush_in |=> line_reg[0] == '0)
    else $error("stuffed phase did not insert zero");

  a_new_sample: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    out_en_in && in_en_in && !flush_in |=>
      line_reg[0] == $past(sample_in))
    else $error("input sample not taken on its phase");
endmodule : interp_stage

// ==== rtl/sample_fifo.sv ====
/*
  Show-ahead FIFO holding assembled I/Q pairs ahead of the filters.
  Assumes one clock; flush empties it in one cycle.
*/
module sample_fifo #(
  parameter int WIDTH = 2 * tx_interp_pkg::SAMPLE_W,
  parameter int DEPTH = tx_interp_pkg::FIFO_WORDS
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  import tx_interp_pkg::*;
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_ready_in && out_valid_out;

  assign in_ready_out = count_reg != FULL_CNT;
  assign out_valid_out = count_reg != '0;
  assign out_data_out = mem[rd_ptr_reg];

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || flush_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= push ? PTR_W'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_reg <= pop ? PTR_W'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
      count_reg <= CNT_W'(count_reg + CNT_W'(push) - CNT_W'(pop));
    end
  end

  a_fifo_no_overrun: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    count_reg == FULL_CNT && in_valid_in && !out_ready_in |=>
      count_reg == FULL_CNT)
    else $error("fifo count moved past full");
endmodule : sample_fifo

// ==== rtl/tx_interp_pkg.sv ====
/*
  Shared constants for the transmit interpolation chain: sample and
  accumulator widths, ratio encodings, tap counts, scale shifts and the
  half coefficient sets (first tap up to and including the center).
  Assumes nothing of its surroundings.
*/
package tx_interp_pkg;
  localparam int SAMPLE_W = 12;
  localparam int COEF_W = 16;
  localparam int ACC_W = 40;
  localparam int FIFO_WORDS = 8;
  localparam int TICK_CNT_W = 3;
  localparam int NUM_CH = 2;
  localparam int NUM_STAGES = 3;

  // Interpolation ratio as log2 of the ratio
  typedef enum logic [1:0] {
    RATIO_1X = 2'h0,
    RATIO_2X = 2'h1,
    RATIO_4X = 2'h2,
    RATIO_8X = 2'h3
  } ratio_t;

  localparam logic PORT_SEL_B = 1'h1;
  localparam logic IQ_FLAG_I = 1'h1;

  localparam int HB0_TAPS = 43;
  localparam int HB1_TAPS = 19;
  localparam int RRC_TAPS = 53;
  // Center coefficient is 2^14, 2^13 and 2^14 (nearly) respectively
  localparam int HB0_SHIFT = 14;
  localparam int HB1_SHIFT = 13;
  localparam int RRC_SHIFT = 14;

  localparam logic signed [COEF_W-1:0] HB0_COEF [HB0_TAPS/2+1] = '{
    12, 0, -32, 0, 72, 0, -140, 0, 252, 0, -422, 0, 682, 0, -1086, 0,
    1778, 0, -3284, 0, 10364, 16384};
  localparam logic signed [COEF_W-1:0] HB1_COEF [HB1_TAPS/2+1] = '{
    26, 0, -138, 0, 466, 0, -1314, 0, 5058, 8191};
  localparam logic signed [COEF_W-1:0] RRC_COEF [RRC_TAPS/2+1] = '{
    -2, -2, 8, -4, -21, 10, 44, -29, -79, 66, 123, -127, -183, 232,
    251, -394, -326, 642, 401, -1034, -469, 1704, 523, -3160, -560,
    9996, 16383};
endpackage : tx_interp_pkg

// ==== rtl/tx_interpolation_filter_chain.sv ====
/*
  Transmit interpolation chain for two channels (I and Q): pin
  synchronisers, data assembler, FIFO, three cascaded 2x stages per
  channel and the converter output registers.
  Assumes ref_clk_in is the converter sample clock; the host port pins
  are asynchronous and held stable around each word strobe edge.
*/
module tx_interpolation_filter_chain #(
  parameter int DATA_W = tx_interp_pkg::SAMPLE_W,
  parameter int FIFO_DEPTH = tx_interp_pkg::FIFO_WORDS
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [1:0] ratio_sel_in,
  input wire logic port_sel_in,
  input wire logic word_strobe_in,
  input wire logic [DATA_W-1:0] port_a_data_in,
  input wire logic port_a_iq_in,
  input wire logic [DATA_W-1:0] port_b_data_in,
  input wire logic port_b_iq_in,
  output logic tx_ready_out,
  output logic sample_drop_out,
  output logic underflow_out,
  output logic dac_valid_out,
  output logic signed [DATA_W-1:0] dac_i_out,
  output logic signed [DATA_W-1:0] dac_q_out
);
  import tx_interp_pkg::*;

  localparam int RAW_W = 2 + 1 + 1 + 2 * (DATA_W + 1);
  localparam int PAIR_W = 2 * DATA_W;
  localparam int CH_I = 0;
  localparam int CH_Q = 1;

  // Pin synchronisers
  logic [RAW_W-1:0] raw;
  logic [RAW_W-1:0] sync1_reg;
  logic [RAW_W-1:0] sync2_reg;
  logic [RAW_W-1:0] sync3_reg;
  logic [RAW_W-1:0] flt_reg;
  logic [1:0] flt_ratio;
  logic flt_sel;
  logic flt_strobe;
  logic b_iq;
  logic a_iq;
  logic [DATA_W-1:0] b_data;
  logic [DATA_W-1:0] a_data;

  assign raw = {ratio_sel_in, port_sel_in, word_strobe_in,
                port_b_iq_in, port_b_data_in, port_a_iq_in, port_a_data_in};
  assign {flt_ratio, flt_sel, flt_strobe, b_iq, b_data, a_iq, a_data} =
    flt_reg;

  // A bit changes only once the second and third stages agree
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      flt_reg <= '0;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      flt_reg <= (sync2_reg & sync3_reg) |
                 (flt_reg & (sync2_reg | sync3_reg));
    end
  end

  // Ratio control and flush
  ratio_t ratio_reg;
  logic flush_reg;
  wire mode_change = flt_ratio != ratio_reg;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ratio_reg <= RATIO_1X;
      flush_reg <= 1'b0;
    end else begin
      ratio_reg <= ratio_t'(flt_ratio);
      flush_reg <= mode_change;
    end
  end

  // Rate enables from one divider
  logic [TICK_CNT_W-1:0] tick_cnt_reg;
  logic [NUM_STAGES:0] tick_vec;
  logic [NUM_STAGES-1:0] st_in_en;
  logic [NUM_STAGES-1:0] st_out_en;
  logic rd_tick;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || flush_reg) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= TICK_CNT_W'(tick_cnt_reg + 1'b1);
    end
  end

  assign tick_vec[0] = 1'b1;
  assign tick_vec[1] = tick_cnt_reg[0];
  assign tick_vec[2] = &tick_cnt_reg[1:0];
  assign tick_vec[3] = &tick_cnt_reg[2:0];

  // read at converter rate over ratio
  assign rd_tick = tick_vec[ratio_reg];

  // stage j runs only when ratio reaches it
  for (genvar j = 1; j <= NUM_STAGES; j++) begin : g_en
    wire on = ratio_reg >= 2'(j);
    assign st_out_en[j-1] = on && tick_vec[2'(ratio_reg - 2'(j))];
    assign st_in_en[j-1] =
      on && tick_vec[2'(ratio_reg - 2'(j) + 2'h1)];
  end

  // Data assembler
  logic strobe_prev_reg;
  logic [DATA_W-1:0] i_hold_reg;
  logic have_i_reg;
  logic drop_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [PAIR_W-1:0] fifo_out_data;
  wire word_take = flt_strobe && !strobe_prev_reg;
  wire [DATA_W-1:0] word_data = (flt_sel == PORT_SEL_B) ? b_data : a_data;
  wire word_iq = (flt_sel == PORT_SEL_B) ? b_iq : a_iq;
  wire word_is_i = word_iq == IQ_FLAG_I;
  wire pair_done = word_take && !word_is_i && have_i_reg && !flush_reg;
  wire fifo_push = pair_done && fifo_in_ready;
  wire fifo_pop = rd_tick && !flush_reg;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || flush_reg) begin
      strobe_prev_reg <= flt_strobe && !rst_in;
      i_hold_reg <= '0;
      have_i_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      strobe_prev_reg <= flt_strobe;
      drop_reg <= pair_done && !fifo_in_ready;
      if (word_take && word_is_i) begin
        i_hold_reg <= word_data;
        have_i_reg <= 1'b1;
      end else if (word_take) begin
        have_i_reg <= 1'b0;
      end
    end
  end

  sample_fifo #(
    .WIDTH(PAIR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .flush_in(flush_reg),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in({i_hold_reg, word_data}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data)
  );

  // Source samples at the input rate; zeros when starved
  logic signed [DATA_W-1:0] src_reg [NUM_CH];
  logic underflow_reg;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || flush_reg) begin
      src_reg[CH_I] <= '0;
      src_reg[CH_Q] <= '0;
      underflow_reg <= 1'b0;
    end else if (rd_tick) begin
      src_reg[CH_I] <= fifo_out_valid ? fifo_out_data[PAIR_W-1:DATA_W] : '0;
      src_reg[CH_Q] <= fifo_out_valid ? fifo_out_data[DATA_W-1:0] : '0;
      underflow_reg <= !fifo_out_valid;
    end
  end

  // Filter chains; index 0 is the source, index s the output of stage s
  logic signed [DATA_W-1:0] chain [NUM_CH][NUM_STAGES+1];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign chain[c][0] = src_reg[c];

    interp_stage #(
      .DATA_W(DATA_W),
      .NTAPS(HB0_TAPS),
      .SHIFT(HB0_SHIFT),
      .COEF(HB0_COEF)
    ) u_first_halfband_stage (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .flush_in(flush_reg),
      .in_en_in(st_in_en[0]),
      .out_en_in(st_out_en[0]),
      .sample_in(chain[c][0]),
      .sample_out(chain[c][1])
    );

    interp_stage #(
      .DATA_W(DATA_W),
      .NTAPS(HB1_TAPS),
      .SHIFT(HB1_SHIFT),
      .COEF(HB1_COEF)
    ) u_second_halfband_stage (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .flush_in(flush_reg),
      .in_en_in(st_in_en[1]),
      .out_en_in(st_out_en[1]),
      .sample_in(chain[c][1]),
      .sample_out(chain[c][2])
    );

    interp_stage #(
      .DATA_W(DATA_W),
      .NTAPS(RRC_TAPS),
      .SHIFT(RRC_SHIFT),
      .COEF(RRC_COEF)
    ) u_root_raised_cosine_stage (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .flush_in(flush_reg),
      .in_en_in(st_in_en[2]),
      .out_en_in(st_out_en[2]),
      .sample_in(chain[c][2]),
      .sample_out(chain[c][3])
    );
  end

  // ratio 1 selects the source directly
  wire signed [DATA_W-1:0] final_i = chain[CH_I][ratio_reg];
  wire signed [DATA_W-1:0] final_q = chain[CH_Q][ratio_reg];

  logic dac_valid_reg;
  logic tx_ready_reg;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || flush_reg) begin
      dac_i_out <= '0;
      dac_q_out <= '0;
      dac_valid_reg <= 1'b0;
    end else begin
      dac_i_out <= final_i;
      dac_q_out <= final_q;
      dac_valid_reg <= dac_valid_reg || (rd_tick && fifo_out_valid);
    end
  end

  // Ready is one cycle stale, so the host may see one drop at full
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tx_ready_reg <= 1'b0;
    end else begin
      tx_ready_reg <= fifo_in_ready && !flush_reg;
    end
  end

  assign tx_ready_out = tx_ready_reg;
  assign sample_drop_out = drop_reg;
  assign underflow_out = underflow_reg;
  assign dac_valid_out = dac_valid_reg;

  a_read_spacing: assert property (
    @(posedge ref_clk_in) disable iff (rst_in || mode_change || flush_reg)
    rd_tick && ratio_reg == RATIO_8X && !mode_change && !flush_reg |=>
      (!rd_tick && !mode_change) [*7] ##1 rd_tick)
    else $error("8x read tick not every eighth cycle");

  a_flush_on_change: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    mode_change |=> flush_reg ##1 !fifo_out_valid)
    else $error("ratio change did not flush");

  a_cumulative_stages: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (ratio_reg < RATIO_4X |-> !st_out_en[1] && !st_out_en[2]) and
    (ratio_reg != RATIO_8X |-> !st_out_en[2]))
    else $error("stage enabled beyond selected ratio");

  a_bypass_direct: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    ratio_reg == RATIO_1X && !flush_reg |=>
      dac_i_out == $past(src_reg[CH_I]) &&
      dac_q_out == $past(src_reg[CH_Q]))
    else $error("bypass did not forward source sample");

  a_last_stage_out: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    ratio_reg == RATIO_8X && !flush_reg |=>
      dac_i_out == $past(chain[CH_I][3]))
    else $error("converter not fed by final stage");

  // Input phase alternates; the output runs every converter clock
  a_half_rate_2x: assert property (
    @(posedge ref_clk_in) disable iff (rst_in || mode_change || flush_reg)
    st_in_en[0] && ratio_reg == RATIO_2X && !mode_change && !flush_reg
      |=> !st_in_en[0] ##1 st_in_en[0])
    else $error("2x stage input not at half converter rate");

  a_pair_push: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    fifo_push |-> $past(word_take && word_is_i, 1) || have_i_reg)
    else $error("pair pushed without a held I word");

  a_drop_when_full: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    pair_done && !fifo_in_ready |=> sample_drop_out && !$past(fifo_push))
    else $error("pair at full FIFO not flagged as dropped");

  a_starved_zero: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    rd_tick && !fifo_out_valid && !flush_reg |=>
      underflow_out && src_reg[CH_I] == '0 && src_reg[CH_Q] == '0)
    else $error("empty read did not feed zeros");
endmodule : tx_interpolation_filter_chain

// ==== tb/host_port_model.sv ====
/*
  Baseband host model: drives the interleaved sample port of the
  transmit chain, one word per strobe.
  Assumes the chain filters its pins over four clocks.
*/
module host_port_model (
  input wire logic ref_clk_in,
  input wire logic port_sel_in,
  output logic word_strobe_out,
  output logic [tx_interp_pkg::SAMPLE_W-1:0] port_a_data_out,
  output logic port_a_iq_out,
  output logic [tx_interp_pkg::SAMPLE_W-1:0] port_b_data_out,
  output logic port_b_iq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import tx_interp_pkg::*;

  initial begin
    word_strobe_out = 1'b0;
    port_a_data_out = '0;
    port_a_iq_out = 1'b0;
    port_b_data_out = '0;
    port_b_iq_out = 1'b0;
  end

  // Lines outside a word keep moving, so a stale value never passes
  task automatic release_lines();
    port_a_data_out = ~port_a_data_out;
    port_a_iq_out = ~port_a_iq_out;
    port_b_data_out = ~port_b_data_out;
    port_b_iq_out = ~port_b_iq_out;
  endtask : release_lines

  // Word held two clocks before and five after the strobe edge
  task automatic send_word(input logic [SAMPLE_W-1:0] data,
      input logic iq, input int gap);
    @(negedge ref_clk_in);
    if (port_sel_in == PORT_SEL_B) begin
      port_a_data_out = ~port_a_data_out;
      port_a_iq_out = ~port_a_iq_out;
      port_b_data_out = data;
      port_b_iq_out = iq;
    end else begin
      port_b_data_out = ~port_b_data_out;
      port_b_iq_out = ~port_b_iq_out;
      port_a_data_out = data;
      port_a_iq_out = iq;
    end
    repeat (2) @(negedge ref_clk_in);
    word_strobe_out = 1'b1;
    repeat (5) @(negedge ref_clk_in);
    word_strobe_out = 1'b0;
    release_lines();
    repeat (3 + gap) @(negedge ref_clk_in);
  endtask : send_word

  task automatic send_pair(input logic [SAMPLE_W-1:0] i_word,
      input logic [SAMPLE_W-1:0] q_word, input int gap);
    send_word(i_word, IQ_FLAG_I, 0);
    send_word(q_word, ~IQ_FLAG_I, gap);
  endtask : send_pair
endmodule : host_port_model

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the transmit interpolation chain, its FIFO
  exercised through the chain's own ports.
  Assumes the host model drives the sample port; clock 50 MHz.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tx_interp_pkg::*;
  localparam int SMAX = 2 ** (SAMPLE_W - 1) - 1;
  logic ref_clk_in, rst_in, port_sel_in, word_strobe_in;
  logic [1:0] ratio_sel_in;
  logic [SAMPLE_W-1:0] port_a_data_in, port_b_data_in;
  logic port_a_iq_in, port_b_iq_in, tx_ready_out, sample_drop_out;
  logic underflow_out, dac_valid_out;
  logic signed [SAMPLE_W-1:0] dac_i_out, dac_q_out;
  int bad_count, total_checks;

  tx_interpolation_filter_chain dut_u (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .ratio_sel_in(ratio_sel_in), .port_sel_in(port_sel_in),
    .word_strobe_in(word_strobe_in), .port_a_data_in(port_a_data_in),
    .port_a_iq_in(port_a_iq_in), .port_b_data_in(port_b_data_in),
    .port_b_iq_in(port_b_iq_in), .tx_ready_out(tx_ready_out),
    .sample_drop_out(sample_drop_out), .underflow_out(underflow_out),
    .dac_valid_out(dac_valid_out), .dac_i_out(dac_i_out),
    .dac_q_out(dac_q_out)
  );
  host_port_model host_u (
    .ref_clk_in(ref_clk_in), .port_sel_in(port_sel_in),
    .word_strobe_out(word_strobe_in), .port_a_data_out(port_a_data_in),
    .port_a_iq_out(port_a_iq_in), .port_b_data_out(port_b_data_in),
    .port_b_iq_out(port_b_iq_in)
  );
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [23:0] seen,
      input logic [23:0] expected);
    total_checks++;
    if (seen !== expected) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", name, expected, seen);
    end
  endtask : check

  // Zero-stuff, full symmetric FIR, round half up, saturate
  function automatic void ref_stage(ref int q[$], input int st);
    int taps, sh, acc, h, hc;
    int u[$], y[$];
    case (st)
      0: begin taps = HB0_TAPS; sh = HB0_SHIFT; end
      1: begin taps = HB1_TAPS; sh = HB1_SHIFT; end
      default: begin taps = RRC_TAPS; sh = RRC_SHIFT; end
    endcase
    foreach (q[m]) begin
      u.push_back(q[m]);
      u.push_back(0);
    end
    for (int n = 0; n < u.size() + taps - 1; n++) begin
      acc = 0;
      for (int k = 0; k < taps; k++) begin
        hc = (k <= taps / 2) ? k : taps - 1 - k;
        case (st)
          0: h = HB0_COEF[hc];
          1: h = HB1_COEF[hc];
          default: h = RRC_COEF[hc];
        endcase
        if (n - k >= 0 && n - k < u.size()) acc += h * u[n - k];
      end
      acc = (acc + (1 <<< (sh - 1))) >>> sh;
      y.push_back(acc > SMAX ? SMAX : (acc < -SMAX - 1 ? -SMAX - 1 : acc));
    end
    q = y;
  endfunction : ref_stage

  task automatic watch(input int ri[$], input int rq[$]);
    int w;
    w = 0;
    while (dac_i_out === '0 && dac_q_out === '0 && w < 800) begin
      @(negedge ref_clk_in);
      w++;
    end
    check("dac_valid_out", 24'(dac_valid_out), 24'(1));
    foreach (ri[k]) begin
      check("dac_i_out", 24'(dac_i_out), 24'(ri[k]));
      check("dac_q_out", 24'(dac_q_out), 24'(rq[k]));
      @(negedge ref_clk_in);
    end
  endtask : watch

  task automatic run_pair(input int r, input int iv, input int qv);
    int ri[$], rq[$];
    ri = {iv};
    rq = {qv};
    for (int s = 0; s < r; s++) begin
      ref_stage(ri, s);
      ref_stage(rq, s);
    end
    while (ri.size() > 1 && ri[0] == 0 && rq[0] == 0) begin
      void'(ri.pop_front());
      void'(rq.pop_front());
    end
    fork
      host_u.send_pair(SAMPLE_W'(iv), SAMPLE_W'(qv), 0);
      watch(ri, rq);
    join
  endtask : run_pair

  task automatic set_ratio(input logic [1:0] r);
    @(negedge ref_clk_in);
    ratio_sel_in = r;
    repeat (10) @(negedge ref_clk_in);
    check("dac_valid_out", 24'(dac_valid_out), 24'(0));
    check("tx_ready_out", 24'(tx_ready_out), 24'(1));
  endtask : set_ratio

  task automatic assembler_order();
    int ri[$], rq[$];
    ri = {32'h0C8};
    rq = {32'h12C};
    fork
      begin
        host_u.send_word(12'h155, ~IQ_FLAG_I, 0);
        host_u.send_word(12'h064, IQ_FLAG_I, 0);
        host_u.send_word(12'h0C8, IQ_FLAG_I, 0);
        host_u.send_word(12'h12C, ~IQ_FLAG_I, 0);
      end
      watch(ri, rq);
    join
  endtask : assembler_order

  task automatic port_b_path();
    @(negedge ref_clk_in);
    port_sel_in = PORT_SEL_B;
    repeat (6) @(negedge ref_clk_in);
    run_pair(0, -5, 9);
    check("underflow_out", 24'(underflow_out), 24'(1));
    port_sel_in = ~PORT_SEL_B;
    repeat (6) @(negedge ref_clk_in);
  endtask : port_b_path

  task automatic ratio_flush();
    int w;
    w = 0;
    host_u.send_pair(12'h7FF, 12'h800, 0);
    repeat (10) @(negedge ref_clk_in);
    check("dac_valid_out", 24'(dac_valid_out), 24'(1));
    // 4x keeps two stages whose lines still hold the 8x tail
    ratio_sel_in = RATIO_4X;
    repeat (8) @(negedge ref_clk_in);
    repeat (200) begin
      @(negedge ref_clk_in);
      if (dac_i_out !== '0 || dac_q_out !== '0 || dac_valid_out !== 1'b0)
        w++;
    end
    check("stale_samples", 24'(w), 24'(0));
    run_pair(2, 1000, -1000);
  endtask : ratio_flush

  // Host pins cannot outpace the reads, so the FIFO is seen in passing
  task automatic fifo_stream();
    int si[$], sq[$];
    int drops, stalls;
    drops = 0;
    stalls = 0;
    set_ratio(RATIO_1X);
    fork
      begin
        host_u.send_pair(12'h123, 12'h456, 0);
        host_u.send_pair(12'h789, 12'h2AB, 0);
      end
      repeat (60) begin
        @(negedge ref_clk_in);
        if (dac_i_out !== '0) begin
          si.push_back(dac_i_out);
          sq.push_back(dac_q_out);
        end
        drops += (sample_drop_out !== 1'b0);
        stalls += (tx_ready_out !== 1'b1);
      end
    join
    check("fifo_count", 24'(si.size()), 24'h000002);
    check("fifo_first_i", 24'(si[0]), 24'h000123);
    check("fifo_first_q", 24'(sq[0]), 24'h000456);
    check("fifo_second_i", 24'(si[1]), 24'h000789);
    check("fifo_second_q", 24'(sq[1]), 24'h0002AB);
    check("sample_drop_out", 24'(drops), 24'h000000);
    check("tx_ready_out", 24'(stalls), 24'h000000);
    check("underflow_out", 24'(underflow_out), 24'h000001);
  endtask : fifo_stream

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    bad_count++;
    complete_run();
  end

  initial begin
    rst_in = 1'b1;
    ratio_sel_in = RATIO_1X;
    port_sel_in = ~PORT_SEL_B;
    bad_count = 0;
    total_checks = 0;
    repeat (5) @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    check("tx_ready_out", 24'(tx_ready_out), 24'(1));
    assembler_order();
    port_b_path();
    for (int r = 1; r < 4; r++) begin
      set_ratio(2'(r));
      run_pair(r, 2047, -2048);
      run_pair(r, 301, -77);
    end
    ratio_flush();
    fifo_stream();
    complete_run();
  end
endmodule : testbench
